/* File: pkg/cbr_consts.vh */
`ifndef CBR_CONSTS_VH
`define CBR_CONSTS_VH
// Configuration byte fetch addresses.
`define CBR_CFG0_ADDR 24'hFF2018
`define CBR_CFG1_ADDR 24'hFF201A
`define CBR_CFG2_ADDR 24'hFF201C
// Page-decode ranges, 16-bit offsets within a page, and the 8-bit page numbers.
`define CBR_SFR_LO 16'h1F00
`define CBR_SFR_HI 16'h1FDF
`define CBR_MSFR_LO 16'h1FE0
`define CBR_MSFR_HI 16'h1FFF
`define CBR_RRAM_HI 16'h03FF
`define CBR_PAGE_ZERO 8'h00
`define CBR_PAGE_ALIAS 8'h10
`define CBR_PAGE_TOP 8'hFF
// Wishbone register byte offsets.
`define CBR_REG_CFG_LEGACY 4'h0
`define CBR_REG_CFG_ONE 4'h4
`define CBR_REG_CFG_ADDR 4'h8
`define CBR_REG_CFG_CS 4'hC
// Fixed bits.
`define CBR_ONE_FIXED 2'h1
`define CBR_ADDR_ONES 5'h1F
`define CBR_CS_ONES 2'h3
// Destination codes.
`define CBR_DST_EXT 2'h0
`define CBR_DST_RRAM 2'h1
`define CBR_DST_SFR 2'h2
`define CBR_DST_MSFR 2'h3
`endif

/* File: verilog/cbr_page_router.v */
`timescale 1ns/1ps
`include "cbr_consts.vh"
// Combinational page router: picks the target of one access.
module cbr_page_router (
  input wire [23:0] addr_in,
  input wire ext_in,
  input wire [7:0] ep_page_in,
  output reg [1:0] dst_out,
  output reg [23:0] ext_addr_out
);
  wire [7:0] page = addr_in[23:16];
  wire [15:0] ofs = addr_in[15:0];
  wire in_rram = (ofs <= `CBR_RRAM_HI);
  wire in_sfr = (ofs >= `CBR_SFR_LO) && (ofs <= `CBR_SFR_HI);
  wire in_msfr = (ofs >= `CBR_MSFR_LO) && (ofs <= `CBR_MSFR_HI);
  always @* begin
    dst_out = `CBR_DST_EXT;
    ext_addr_out = addr_in;
    if (!ext_in) begin
      if (in_rram) dst_out = `CBR_DST_RRAM;
      else if (in_sfr) dst_out = `CBR_DST_SFR;
      else if (in_msfr && ep_page_in == `CBR_PAGE_ZERO) dst_out = `CBR_DST_MSFR;
    end else if (in_msfr) begin
      dst_out = `CBR_DST_MSFR;
    end else if (page == `CBR_PAGE_ZERO && (in_rram || in_sfr)) begin
      dst_out = in_rram ? `CBR_DST_RRAM : `CBR_DST_SFR;
    end else if (page == `CBR_PAGE_ALIAS) begin
      ext_addr_out = {`CBR_PAGE_ZERO, ofs};
    end
  end
endmodule // cbr_page_router

/* File: verilog/cbr_wait_timer.v */
`timescale 1ns/1ps
`include "cbr_consts.vh"
// Counts inserted wait states; done pulses when count reaches the load value.
module cbr_wait_timer (
  input wire clk_in,
  input wire rstn_in,
  input wire start_in,
  input wire [1:0] waits_in,
  output wire done_out
);
  reg [2:0] cnt_q;
  reg run_q;
  reg [1:0] lim_q;
  assign done_out = run_q && (cnt_q[1:0] == lim_q);
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 3'h0;
      run_q <= 1'b0;
      lim_q <= 2'h0;
    end else if (start_in) begin
      cnt_q <= 3'h0;
      run_q <= 1'b1;
      lim_q <= waits_in;
    end else if (done_out) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule // cbr_wait_timer

/* File: verilog/cbr_config_loader.v */
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "cbr_consts.vh"
module cbr_config_loader (
  input wire clk_in,
  input wire rstn_in,
  // Program memory fetch port.
  output reg mem_req_out,
  output reg [23:0] mem_addr_out,
  input wire [7:0] mem_data_in,
  input wire mem_ack_in,
  // Core access to route.
  input wire [23:0] acc_addr_in,
  input wire acc_ext_in,
  input wire acc_we_in,
  input wire [1:0] acc_be_in,
  input wire [15:0] acc_wdata_in,
  output reg [1:0] acc_dst_out,
  output reg [23:0] acc_ext_addr_out,
  output reg [15:0] acc_rdata_out,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Decoded configuration.
  output reg cfg_done_out,
  output reg [1:0] timing_mode_out,
  output reg addr16_out,
  output reg rom_page00_out,
  output reg rom_pageff_out,
  output reg split_bus_out,
  output reg watchdog_enable_out,
  output reg [7:0] ep_page_out
);
  localparam [4:0] ST_B0 = 5'h01;
  localparam [4:0] ST_W1 = 5'h02;
  localparam [4:0] ST_B1 = 5'h04;
  localparam [4:0] ST_B2 = 5'h08;
  localparam [4:0] ST_RUN = 5'h10;

  // The loader keeps separate images for both variants so software can read either.
  reg [4:0] st_q;
  reg [7:0] legacy_q;
  reg [7:0] one_q;
  reg [7:0] addrcfg_q;
  reg [7:0] cs_q;
  reg [7:0] ep_page_q;
  // Small windowed peripheral register file, 16 words deep, 16 bits wide.
  reg [15:0] sfr_q [0:15];
  reg [7:0] mem_sync1_q;
  reg [7:0] mem_sync2_q;
  reg ack_sync1_q;
  reg ack_sync2_q;
  reg ack_prev_q;
  reg wait_go_q;
  wire wait_done;
  wire [1:0] rdst;
  wire [23:0] rext;
  wire ack_rise = ack_sync2_q && !ack_prev_q;
  integer i;

  cbr_wait_timer u_wait (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(wait_go_q),
    .waits_in(cs_q[5:4]),
    .done_out(wait_done)
  );

  cbr_page_router u_route (
    .addr_in(acc_addr_in),
    .ext_in(acc_ext_in),
    .ep_page_in(ep_page_q),
    .dst_out(rdst),
    .ext_addr_out(rext)
  );

  // Byte-lane merge keeps the other byte of a word register intact.
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] be;
    begin
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mem_sync1_q <= 8'h00;
      mem_sync2_q <= 8'h00;
      ack_sync1_q <= 1'b0;
      ack_sync2_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      mem_sync1_q <= mem_data_in;
      mem_sync2_q <= mem_sync1_q;
      ack_sync1_q <= mem_ack_in;
      ack_sync2_q <= ack_sync1_q;
      ack_prev_q <= ack_sync2_q;
    end
  end

  // Fetch sequencer; the memory holds 20H in the neighbouring bytes.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_B0;
      mem_req_out <= 1'b0;
      mem_addr_out <= `CBR_CFG0_ADDR;
      legacy_q <= 8'h00;
      one_q <= {2'h0, `CBR_ONE_FIXED, 4'h0};
      addrcfg_q <= {`CBR_ADDR_ONES, 3'h0};
      cs_q <= {`CBR_CS_ONES, 6'h00};
      wait_go_q <= 1'b0;
    end else begin
      wait_go_q <= 1'b0;
      case (st_q)
        ST_B0: begin
          mem_req_out <= 1'b1;
          mem_addr_out <= `CBR_CFG0_ADDR;
          if (ack_rise) begin
            mem_req_out <= 1'b0;
            legacy_q <= mem_sync2_q;
            cs_q <= {`CBR_CS_ONES, mem_sync2_q[5:0]};
            wait_go_q <= 1'b1;
            st_q <= ST_W1;
          end
        end
        ST_W1: begin
          mem_addr_out <= `CBR_CFG1_ADDR;
          if (wait_done) begin
            st_q <= ST_B1;
          end
        end
        ST_B1: begin
          mem_req_out <= 1'b1;
          if (ack_rise) begin
            mem_req_out <= 1'b0;
            one_q <= {mem_sync2_q[7:6], `CBR_ONE_FIXED, mem_sync2_q[3:0]};
            if (mem_sync2_q[0]) begin
              st_q <= ST_B2;
            end else begin
              st_q <= ST_RUN;
            end
          end
        end
        ST_B2: begin
          mem_req_out <= 1'b1;
          mem_addr_out <= `CBR_CFG2_ADDR;
          if (ack_rise) begin
            mem_req_out <= 1'b0;
            addrcfg_q <= {`CBR_ADDR_ONES, mem_sync2_q[2:1], 1'b0};
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          mem_req_out <= 1'b0;
        end
        default: begin
          st_q <= ST_B0;
        end
      endcase
    end
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timing_mode_out <= 2'h0;
      addr16_out <= 1'b0;
      rom_page00_out <= 1'b0;
      rom_pageff_out <= 1'b1;
      split_bus_out <= 1'b0;
      watchdog_enable_out <= 1'b0;
      ep_page_out <= 8'h00;
      acc_dst_out <= `CBR_DST_EXT;
      acc_ext_addr_out <= 24'h000000;
      cfg_done_out <= 1'b0;
    end else begin
      // Done rises with the decoded outputs, so no reader ever sees it ahead of them.
      cfg_done_out <= (st_q == ST_RUN);
      timing_mode_out <= one_q[7:6];
      addr16_out <= addrcfg_q[1];
      rom_page00_out <= addrcfg_q[2];
      rom_pageff_out <= 1'b1;
      split_bus_out <= cs_q[3];
      watchdog_enable_out <= one_q[3];
      ep_page_out <= ep_page_q;
      acc_dst_out <= rdst;
      acc_ext_addr_out <= rext;
    end
  end

  // Peripheral registers; index from address bits 4:1 windows into the file.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (i = 0; i < 16; i = i + 1) begin
        sfr_q[i] <= 16'h0000;
      end
      ep_page_q <= 8'h00;
      acc_rdata_out <= 16'h0000;
    end else begin
      acc_rdata_out <= sfr_q[acc_addr_in[4:1]];
      if (acc_we_in && rdst != `CBR_DST_EXT) begin
        sfr_q[acc_addr_in[4:1]] <= merge(sfr_q[acc_addr_in[4:1]], acc_wdata_in, acc_be_in);
        if (rdst == `CBR_DST_MSFR && acc_addr_in[4:0] == 5'h00 && acc_be_in[0]) begin
          ep_page_q <= acc_wdata_in[7:0];
        end
      end
    end
  end

  // Wishbone slave: one wait cycle, ack for one cycle, unmapped reads zero.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_adr_i == `CBR_REG_CFG_LEGACY) begin
        wb_dat_o <= {24'h000000, legacy_q};
      end else if (wb_adr_i == `CBR_REG_CFG_ONE) begin
        wb_dat_o <= {24'h000000, one_q};
      end else if (wb_adr_i == `CBR_REG_CFG_ADDR) begin
        wb_dat_o <= {24'h000000, addrcfg_q};
      end else if (wb_adr_i == `CBR_REG_CFG_CS) begin
        wb_dat_o <= {24'h000000, cs_q};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule // cbr_config_loader

/* File: test/cbr_config_loader_assertions.sv */
`timescale 1ns/1ps
`include "cbr_consts.vh"
module cbr_config_loader_chk (
  input wire clk_in,
  input wire rstn_in,
  input wire mem_req_out,
  input wire [23:0] mem_addr_out,
  input wire [23:0] acc_addr_in,
  input wire acc_ext_in,
  input wire [1:0] acc_dst_out,
  input wire [23:0] acc_ext_addr_out,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire cfg_done_out,
  input wire [1:0] timing_mode_out,
  input wire addr16_out,
  input wire rom_page00_out,
  input wire rom_pageff_out
);
  wire [7:0] pg = acc_addr_in[23:16];
  // Mapped peripheral offsets follow their own page rule, so the page checks leave them out.
  wire msfr = (acc_addr_in[15:5] == 11'h0FF);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register bus answer late");
  chk_addr_ones: assert property (wb_ack_o && $past(wb_adr_i) == 4'h8 |->
    wb_dat_o[7:3] == 5'h1F && !wb_dat_o[0]) else $error("addressing fixed bits wrong");
  chk_cs_ones: assert property (wb_ack_o && $past(wb_adr_i) == 4'hC |->
    wb_dat_o[7:6] == 2'h3) else $error("chip-select fixed bits wrong");
  chk_one_fixed: assert property (wb_ack_o && $past(wb_adr_i) == 4'h4 |->
    wb_dat_o[5:4] == 2'h1) else $error("register one fixed bits wrong");
  chk_fetch_addr: assert property (mem_req_out |->
    mem_addr_out inside {`CBR_CFG0_ADDR, `CBR_CFG1_ADDR, `CBR_CFG2_ADDR})
    else $error("fetch address illegal");
  chk_cfg_frozen: assert property (cfg_done_out && $past(cfg_done_out) |->
    $stable({timing_mode_out, addr16_out, rom_page00_out})) else $error("config changed");
  chk_pageff_on: assert property (rom_pageff_out)
    else $error("page FF mapping lost");
  chk_alias_ext: assert property (acc_ext_in && pg == 8'h10 && !msfr |=>
    acc_dst_out == `CBR_DST_EXT && acc_ext_addr_out == {8'h00, $past(acc_addr_in[15:0])})
    else $error("alias page not sent to page zero");
  chk_ext_far: assert property (acc_ext_in && pg != 8'h00 && !msfr |=>
    acc_dst_out == `CBR_DST_EXT) else $error("extended far page not external");
  chk_ext_msfr: assert property (acc_ext_in && msfr |=>
    acc_dst_out == `CBR_DST_MSFR) else $error("extended mapped register not reached");
  chk_sfr_every: assert property (!acc_ext_in && acc_addr_in[15:8] == 8'h1F &&
    acc_addr_in[7:5] != 3'h7 |=> acc_dst_out == `CBR_DST_SFR) else $error("sfr hole missing");
  cover property (cfg_done_out && addr16_out);
  cover property (wb_ack_o && wb_dat_o == 32'h0);
  cover property (acc_dst_out == `CBR_DST_MSFR);
endmodule // cbr_config_loader_chk

bind cbr_config_loader cbr_config_loader_chk cbr_config_loader_chk_inst (.clk_in, .rstn_in,
  .mem_req_out, .mem_addr_out, .acc_addr_in, .acc_ext_in, .acc_dst_out, .acc_ext_addr_out,
  .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .cfg_done_out, .timing_mode_out,
  .addr16_out, .rom_page00_out, .rom_pageff_out);

/* File: test/cbr_mem_model.sv */
`timescale 1ns/1ps
`include "cbr_consts.vh"
module cbr_mem_model (
  input wire clk_in,
  input wire req_in,
  input wire [23:0] addr_in,
  input wire ld2_in,
  input wire [2:0] dly_in,
  output reg ack_out,
  output reg [7:0] data_out
);
  reg [2:0] cnt = 3'h0;
  reg [7:0] val;
  initial ack_out = 1'b0;
  initial data_out = 8'h5A;
  always @* begin
    case (addr_in)
      `CBR_CFG0_ADDR: val = 8'hAD;
      `CBR_CFG1_ADDR: val = {7'h4E, ld2_in};
      `CBR_CFG2_ADDR: val = 8'hFE;
      default: val = 8'h20;
    endcase
  end
  // A released bus toggles each cycle, so a late sample sees the old byte only every second cycle.
  always @(posedge clk_in) begin
    if (!req_in) begin
      ack_out <= 1'b0;
      cnt <= 3'h0;
      data_out <= ~data_out;
    end else if (cnt != dly_in) begin
      cnt <= cnt + 3'h1;
    end else begin
      ack_out <= 1'b1;
      data_out <= val;
    end
  end
endmodule // cbr_mem_model

/* File: test/test_config_byte_and_page_router.sv */
`timescale 1ns/1ps
`include "cbr_consts.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_config_byte_and_page_router;
  reg clk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [23:0] acc_addr = 24'h0;
  reg acc_ext = 1'b0;
  reg acc_we = 1'b0;
  reg [1:0] acc_be = 2'h0;
  reg [15:0] acc_wdata = 16'h0;
  reg wb_cyc = 1'b0;
  reg wb_stb = 1'b0;
  reg wb_we = 1'b0;
  reg [3:0] wb_adr = 4'h0;
  reg [3:0] wb_sel = 4'hF;
  reg [31:0] wb_wd = 32'h000000FF;
  reg ld2 = 1'b1;
  reg [2:0] dly = 3'h0;
  reg req_d = 1'b0;
  wire mem_req, mem_ack, cfg_done, addr16, page00, pageff, split, wdog, ack;
  wire [23:0] mem_addr, xaddr;
  wire [7:0] mem_data, ep_page;
  wire [1:0] dst, tmode;
  wire [15:0] rdata;
  wire [31:0] wb_dat;
  integer error_cnt = 0, n_checks = 0, cyc = 0, i, gap = 0;
  reg [23:0] fq[$];
  reg [11:0] wrow [0:4] = '{12'h0AD, 12'h49D, 12'h8FE, 12'hCED, 12'h200};
  reg [50:0] rows [0:5] = '{{24'h051F10, 1'b0, 2'h2, 24'h0}, {24'h050100, 1'b0, 2'h1, 24'h0},
    {24'h001F10, 1'b1, 2'h2, 24'h0}, {24'h051F10, 1'b1, 2'h0, 24'h051F10},
    {24'h101FBA, 1'b1, 2'h0, 24'h001FBA}, {24'h000100, 1'b1, 2'h1, 24'h0}};
  cbr_config_loader cbr_config_loader_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .mem_req_out(mem_req), .mem_addr_out(mem_addr), .mem_data_in(mem_data),
    .mem_ack_in(mem_ack), .acc_addr_in(acc_addr), .acc_ext_in(acc_ext), .acc_we_in(acc_we),
    .acc_be_in(acc_be), .acc_wdata_in(acc_wdata), .acc_dst_out(dst), .acc_ext_addr_out(xaddr),
    .acc_rdata_out(rdata), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .cfg_done_out(cfg_done), .timing_mode_out(tmode), .addr16_out(addr16),
    .rom_page00_out(page00), .rom_pageff_out(pageff), .split_bus_out(split),
    .watchdog_enable_out(wdog), .ep_page_out(ep_page));
  cbr_mem_model cbr_mem_model_inst (.clk_in(clk_in), .req_in(mem_req), .addr_in(mem_addr),
    .ld2_in(ld2), .dly_in(dly), .ack_out(mem_ack), .data_out(mem_data));
  always #10 clk_in = ~clk_in;
  task conclude;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Fetch order is logged here so the load can be judged after it finishes.
  always @(posedge clk_in) begin
    req_d <= mem_req;
    if (mem_req === 1'b1 && req_d === 1'b0) fq.push_back(mem_addr);
    if (mem_req === 1'b0 && fq.size() == 1) gap = gap + 1;
    cyc = cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      conclude();
    end
  end
  task wb_xfer(input [3:0] a, input w, input [31:0] e);
    begin
      wb_adr <= a;
      wb_we <= w;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      @(posedge clk_in);
      while (ack !== 1'b1) @(posedge clk_in);
      if (!w) `CHK(wb_dat, e)
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task acc(input [23:0] a, input x, input w, input [1:0] be, input [15:0] d);
    begin
      acc_addr <= a;
      acc_ext <= x;
      acc_we <= w;
      acc_be <= be;
      acc_wdata <= d;
      @(posedge clk_in);
      acc_we <= 1'b0;
      @(posedge clk_in);
      // The page register output trails its register by one more edge.
      @(posedge clk_in);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    `CHK({pageff, cfg_done, mem_addr}, {2'b10, `CBR_CFG0_ADDR})
    rstn_in <= 1'b1;
    while (cfg_done !== 1'b1) @(posedge clk_in);
    `CHK({fq[0], fq[1], fq[2]}, {`CBR_CFG0_ADDR, `CBR_CFG1_ADDR, `CBR_CFG2_ADDR})
    // Byte zero asks for two waits; the fetch handshake adds three idle cycles of its own.
    `CHK(gap, 5)
    `CHK(tmode, 2'h2)
    `CHK({wdog, split, addr16, page00}, 4'hF)
    $display("test load done");
    for (i = 0; i < 5; i++) wb_xfer(wrow[i][11:8], 1'b0, {24'h0, wrow[i][7:0]});
    // A write must be ignored: the configuration is frozen once loaded.
    wb_xfer(4'h4, 1'b1, 32'h0);
    wb_xfer(4'h4, 1'b0, 32'h0000009D);
    $display("test registers done");
    acc(24'h001FE0, 1'b1, 1'b1, 2'h1, 16'h0003);
    `CHK(ep_page, 8'h03)
    for (i = 0; i < 6; i++) begin
      acc(rows[i][50:27], rows[i][26], 1'b0, 2'h3, 16'h0);
      `CHK(dst, rows[i][25:24])
      if (rows[i][25:24] == 2'h0) `CHK(xaddr, rows[i][23:0])
    end
    acc(24'h001FE0, 1'b0, 1'b1, 2'h1, 16'h0000);
    `CHK({dst == `CBR_DST_MSFR, ep_page}, 9'h003)
    acc(24'h001FE0, 1'b1, 1'b1, 2'h1, 16'h0000);
    acc(24'h001FE0, 1'b0, 1'b0, 2'h3, 16'h0);
    `CHK({dst, ep_page}, {`CBR_DST_MSFR, 8'h00})
    acc(24'h001F04, 1'b1, 1'b1, 2'h3, 16'hA5C3);
    acc(24'h001F04, 1'b1, 1'b1, 2'h1, 16'h0011);
    acc(24'h001F04, 1'b1, 1'b0, 2'h3, 16'h0);
    `CHK(rdata, 16'hA511)
    acc(24'h001F04, 1'b0, 1'b1, 2'h2, 16'h7700);
    acc(24'h001F04, 1'b1, 1'b0, 2'h3, 16'h0);
    `CHK(rdata, 16'h7711)
    $display("test access done");
    ld2 <= 1'b0;
    dly <= 3'h3;
    rstn_in <= 1'b0;
    @(posedge clk_in);
    fq.delete();
    gap = 0;
    rstn_in <= 1'b1;
    while (cfg_done !== 1'b1) @(posedge clk_in);
    `CHK({fq.size(), fq[1]}, {32'h2, `CBR_CFG1_ADDR})
    `CHK(gap, 5)
    // Without byte two the addressing image keeps its reset value.
    `CHK({addr16, page00}, 2'b00)
    $display("test second reset done");
    conclude();
  end
endmodule // test_config_byte_and_page_router
